// ### hdl/ebw_cycle.sv
// Chip-select-five access cycle engine with external wait termination.
// Assumes requests, config and the wait input are synchronous to clk.
// Functional notes
// RULE1 - Read strobe delay follows read assert field
// RULE2 - Read byte enables only when control bit clear
// RULE3 - Read start: address and chip select together
// RULE4 - Write start: address and write strobe together
// RULE5 - Write select and byte delays follow fields
// RULE6 - Internal wait mode ignores external wait input
// RULE7 - Peripheral asserts wait within 1020 clocks
// RULE8 - Wait low 0..1019 clocks, 1..1020 wide
// RULE9 - Read strobe negates 2-3 clocks after wait
// RULE10 - Read data ready one clock after wait
// RULE11 - Read strobe drops before chip select
// RULE12 - Write strobe negates 1-2 clocks after wait
// RULE13 - Write strobe drops before chip select
// RULE14 - Write data held two clocks after strobe
// RULE15 - DMA back-to-back: one idle clock minimum
// RULE16 - Chip select lasts at least three clocks
// RULE17 - Time-out raises bus error after 1022 counts
// RULE18 - Only region five uses external acknowledge
// RULE19 - Wait sampled synchronously, state steps on clock
`timescale 1ns/1ps
module ebw_cycle (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Configuration
	input wire ebw_pkg::ebw_cfg_s cfg,
	input wire logic region_is_five,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire ebw_pkg::ebw_req_s req,
	// Answer
	output logic done,
	output logic bus_error,
	output logic [ebw_pkg::DATA_W-1:0] rdata,
	// Pins
	input wire logic data_ack_input_n,
	input wire logic [ebw_pkg::DATA_W-1:0] din,
	output ebw_pkg::ebw_pins_s pins
);

	typedef struct packed {
		ebw_pkg::ebw_state_e state;
		ebw_pkg::ebw_req_s cur;
		logic ack_seen;
		logic [1:0] ack_dly;
		logic [1:0] tail;
		logic [1:0] hold;
		logic done;
		logic bus_error;
		logic [ebw_pkg::DATA_W-1:0] rdata;
		ebw_pkg::ebw_pins_s pins;
	} ebw_st_s;

	ebw_st_s st_ff;
	ebw_st_s nxt_st;
	logic [10:0] age;
	logic age_clr;
	logic use_ext_ack;
	logic ack_now;
	logic [3:0] strobe_dly;
	logic [3:0] cs_dly;
	logic cs_on_n;

	// Phase counter from cycle start; shared by delays, wait and time-out
	ebw_cnt u_age (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.clr(age_clr),
		.inc(st_ff.state == ebw_pkg::ST_ACTIVE),
		.count(age)
	);

	// External acknowledge only on region five with the external source
	assign use_ext_ack = cfg.ack_source_select && region_is_five; // RULE18
	// Internal mode never looks at the pin, so it may float
	assign ack_now = use_ext_ack ? !data_ack_input_n // RULE6 RULE19
		: (age >= {5'h00, cfg.wait_state_count});
	assign strobe_dly = st_ff.cur.write ? cfg.write_enable_assert_delay
		: cfg.read_strobe_assert_delay;
	assign cs_dly = st_ff.cur.write ? cfg.select_assert_delay : 4'h0;
	assign req_ready = (st_ff.state == ebw_pkg::ST_IDLE);
	assign age_clr = (st_ff.state != ebw_pkg::ST_ACTIVE);
	// Select delay counts clocks from cycle start; zero means at once
	assign cs_on_n = (cs_dly != 4'h0) && (age < {7'h00, cs_dly - 4'h1});

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.bus_error = 1'b0;
		unique case (st_ff.state)
			ebw_pkg::ST_IDLE: begin
				if (req_valid) begin
					nxt_st.cur = req;
					nxt_st.ack_seen = 1'b0;
					nxt_st.ack_dly = 2'h0;
					nxt_st.state = ebw_pkg::ST_ACTIVE;
					nxt_st.pins.addr = req.addr; // RULE3 RULE4
					nxt_st.pins.rw_n = !req.write; // RULE4
					// Writes may delay the select; reads assert it now
					nxt_st.pins.chip_select_five_n =
						req.write && (cfg.select_assert_delay != 4'h0); // RULE3 RULE5
					if (req.write) begin
						nxt_st.pins.dout = req.wdata;
						nxt_st.pins.dout_oe = 1'b1;
					end
				end
			end
			ebw_pkg::ST_ACTIVE: begin
				nxt_st.pins.chip_select_five_n = cs_on_n; // RULE5
				if (age >= {7'h00, strobe_dly}) begin
					if (st_ff.cur.write) begin
						nxt_st.pins.byte_lane_enable_n = ~st_ff.cur.byte_sel; // RULE5
					end else begin
						nxt_st.pins.oe_n = 1'b0; // RULE1
						if (!cfg.byte_enable_control) begin
							nxt_st.pins.byte_lane_enable_n = ~st_ff.cur.byte_sel; // RULE2
						end
					end
				end
				if (ack_now) begin
					nxt_st.ack_seen = 1'b1;
				end
				if (ack_now || st_ff.ack_seen) begin
					nxt_st.ack_dly = st_ff.ack_dly + 2'h1;
				end
				// Data valid one clock after wait; capture at strobe end
				if (st_ff.ack_seen && !st_ff.cur.write) begin
					nxt_st.rdata = din; // RULE10
				end
				// Select must already be low so its pulse reaches three clocks
				if ((st_ff.ack_seen || ack_now) && age >= 11'd2 &&
					!st_ff.pins.chip_select_five_n &&
					st_ff.ack_dly + 2'h1 >= (st_ff.cur.write ?
					2'(ebw_pkg::WR_WAIT_CLKS) : 2'(ebw_pkg::RD_WAIT_CLKS))) begin
					nxt_st.pins.oe_n = 1'b1; // RULE9
					nxt_st.pins.rw_n = 1'b1; // RULE12
					nxt_st.pins.byte_lane_enable_n = 2'h3;
					nxt_st.pins.chip_select_five_n = 1'b0; // RULE16
					nxt_st.tail = st_ff.cur.write ?
						2'(ebw_pkg::WR_TAIL_CLKS) : 2'(ebw_pkg::RD_TAIL_CLKS);
					nxt_st.hold = 2'(ebw_pkg::WDATA_HOLD_CLKS);
					nxt_st.state = ebw_pkg::ST_TAIL; // RULE11 RULE13
				end else if (use_ext_ack &&
					age >= 11'(ebw_pkg::TIMEOUT_COUNTS)) begin
					// Peripheral never answered; abandon the cycle
					nxt_st.bus_error = 1'b1; // RULE17
					nxt_st.pins = '{chip_select_five_n: 1'b1, rw_n: 1'b1,
						oe_n: 1'b1, byte_lane_enable_n: 2'h3,
						addr: st_ff.pins.addr, dout: st_ff.pins.dout,
						dout_oe: 1'b0};
					nxt_st.state = ebw_pkg::ST_GAP;
				end
			end
			ebw_pkg::ST_TAIL: begin
				nxt_st.tail = st_ff.tail - 2'h1;
				if (st_ff.hold != 2'h0) begin
					nxt_st.hold = st_ff.hold - 2'h1;
				end else begin
					nxt_st.pins.dout_oe = 1'b0;
				end
				if (st_ff.tail <= 2'h1) begin
					nxt_st.pins.chip_select_five_n = 1'b1; // RULE11 RULE13
					nxt_st.state = ebw_pkg::ST_STROBE_END;
				end
			end
			ebw_pkg::ST_STROBE_END: begin
				// Write data still held until its count expires
				if (st_ff.hold > 2'h1) begin
					nxt_st.hold = st_ff.hold - 2'h1;
				end else begin
					nxt_st.pins.dout_oe = 1'b0; // RULE14
					nxt_st.done = 1'b1;
					nxt_st.state = ebw_pkg::ST_GAP;
				end
			end
			ebw_pkg::ST_GAP: begin
				// One idle clock keeps DMA bursts from merging selects
				nxt_st.state = ebw_pkg::ST_IDLE; // RULE15
			end
			default: begin
				nxt_st.state = ebw_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
			st_ff.state <= ebw_pkg::ST_IDLE;
			st_ff.pins.chip_select_five_n <= 1'b1;
			st_ff.pins.rw_n <= 1'b1;
			st_ff.pins.oe_n <= 1'b1;
			st_ff.pins.byte_lane_enable_n <= 2'h3;
		end else if (ce) begin
			st_ff <= nxt_st; // RULE19
		end
	end

	assign pins = st_ff.pins;
	assign done = st_ff.done;
	assign bus_error = st_ff.bus_error;
	assign rdata = st_ff.rdata;

	// Helper: cycles chip select has been low
	logic [10:0] cs_low_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_low_cnt <= 11'h000;
		end else if (ce) begin
			cs_low_cnt <= st_ff.pins.chip_select_five_n ? 11'h000
				: cs_low_cnt + 11'h001;
		end
	end

	property p_cs_width;
		@(posedge clk) disable iff (!arst_n)
		(ce && $rose(st_ff.pins.chip_select_five_n)) |-> cs_low_cnt >= 11'd3;
	endproperty
	a_cs_width: assert property (p_cs_width) // RULE16
		else $error("chip select pulse shorter than three clocks");

	property p_cs_gap;
		@(posedge clk) disable iff (!arst_n)
		$rose(st_ff.pins.chip_select_five_n) |=> st_ff.pins.chip_select_five_n;
	endproperty
	a_cs_gap: assert property (p_cs_gap) // RULE15
		else $error("chip select reasserted without idle clock");

	property p_rd_start;
		@(posedge clk) disable iff (!arst_n)
		(ce && req_valid && req_ready && !req.write) |=>
			(!st_ff.pins.chip_select_five_n && st_ff.pins.addr == $past(req.addr));
	endproperty
	a_rd_start: assert property (p_rd_start) // RULE3
		else $error("read start without select and address");

	property p_wr_start;
		@(posedge clk) disable iff (!arst_n)
		(ce && req_valid && req_ready && req.write) |=>
			(!st_ff.pins.rw_n && st_ff.pins.addr == $past(req.addr));
	endproperty
	a_wr_start: assert property (p_wr_start) // RULE4
		else $error("write start without strobe and address");

	property p_oe_before_cs;
		@(posedge clk) disable iff (!arst_n)
		(ce && $rose(st_ff.pins.oe_n) && !st_ff.cur.write &&
			st_ff.state == ebw_pkg::ST_TAIL) |->
			!st_ff.pins.chip_select_five_n ##1 st_ff.pins.chip_select_five_n;
	endproperty
	a_oe_before_cs: assert property (p_oe_before_cs) // RULE11
		else $error("read strobe to select spacing wrong");

	property p_rw_before_cs;
		@(posedge clk) disable iff (!arst_n)
		(ce && $rose(st_ff.pins.rw_n) && st_ff.state == ebw_pkg::ST_TAIL) |->
			!st_ff.pins.chip_select_five_n ##2 st_ff.pins.chip_select_five_n;
	endproperty
	a_rw_before_cs: assert property (p_rw_before_cs) // RULE13
		else $error("write strobe to select spacing wrong");

	property p_wdata_hold;
		@(posedge clk) disable iff (!arst_n)
		(ce && $rose(st_ff.pins.rw_n) && st_ff.state == ebw_pkg::ST_TAIL) |->
			st_ff.pins.dout_oe [*2];
	endproperty
	a_wdata_hold: assert property (p_wdata_hold) // RULE14
		else $error("write data dropped too early");

	property p_rd_ebe;
		@(posedge clk) disable iff (!arst_n)
		(!st_ff.cur.write && cfg.byte_enable_control &&
			st_ff.state == ebw_pkg::ST_ACTIVE && $stable(cfg))
			|=> st_ff.pins.byte_lane_enable_n == 2'h3;
	endproperty
	a_rd_ebe: assert property (p_rd_ebe) // RULE2
		else $error("read byte enable despite control bit");

	property p_timeout;
		@(posedge clk) disable iff (!arst_n)
		bus_error |-> $past(age) >= 11'd1022;
	endproperty
	a_timeout: assert property (p_timeout) // RULE17
		else $error("bus error before time-out count");

	property p_rd_wait_oe;
		@(posedge clk) disable iff (!arst_n || !ce)
		(st_ff.state == ebw_pkg::ST_ACTIVE && !st_ff.cur.write &&
			use_ext_ack && ack_now && !st_ff.ack_seen) |->
			##[2:3] st_ff.pins.oe_n;
	endproperty
	a_rd_wait_oe: assert property (p_rd_wait_oe) // RULE9
		else $error("read strobe late after wait");

	property p_wr_wait_rw;
		@(posedge clk) disable iff (!arst_n || !ce)
		(st_ff.state == ebw_pkg::ST_ACTIVE && st_ff.cur.write &&
			use_ext_ack && ack_now && !st_ff.ack_seen &&
			!st_ff.pins.chip_select_five_n) |-> ##[1:2] st_ff.pins.rw_n;
	endproperty
	a_wr_wait_rw: assert property (p_wr_wait_rw) // RULE12
		else $error("write strobe late after wait");

	c_read: cover property (@(posedge clk) disable iff (!arst_n)
		done && !st_ff.cur.write);
	c_write: cover property (@(posedge clk) disable iff (!arst_n)
		done && st_ff.cur.write);
	c_dma: cover property (@(posedge clk) disable iff (!arst_n)
		done && st_ff.cur.dma ##3 !st_ff.pins.chip_select_five_n);
	c_error: cover property (@(posedge clk) disable iff (!arst_n) bus_error);

endmodule

// ### hdl/ebw_pkg.sv
// Package for the chip-select-five wait/acknowledge cycle engine.
// Assumes one system clock; all pins synchronous to it.
package ebw_pkg;

	localparam int CLK_MHZ = 20;
	// Bus time-out window in system clock counts
	localparam int TIMEOUT_COUNTS = 1022;
	// Shortest chip-select pulse, in clocks
	localparam int CS_MIN_CLKS = 3;
	// Chip-select idle gap between back-to-back accesses, in clocks
	localparam int CS_GAP_CLKS = 1;
	// Write data kept after the write strobe negates, in clocks
	localparam int WDATA_HOLD_CLKS = 2;
	// Read strobe drop to chip-select drop, whole clocks
	localparam int RD_TAIL_CLKS = 1;
	// Write strobe drop to chip-select drop, whole clocks
	localparam int WR_TAIL_CLKS = 2;
	// Wait seen to strobe negation, in clocks
	localparam int RD_WAIT_CLKS = 2;
	localparam int WR_WAIT_CLKS = 1;
	// Bit position of the byte-enable control bit in the control word
	localparam int BYTE_EN_CTRL_BIT = 11;
	localparam logic [5:0] WSC_ALL_ONES = 6'h3f;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_GAP,
		ST_ACTIVE,
		ST_STROBE_END,
		ST_TAIL
	} ebw_state_e;

	typedef struct packed {
		logic [5:0] wait_state_count;
		logic ack_source_select;
		logic byte_enable_control;
		logic [3:0] read_strobe_assert_delay;
		logic [3:0] select_assert_delay;
		logic [3:0] write_enable_assert_delay;
	} ebw_cfg_s;

	typedef struct packed {
		logic write;
		logic dma;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] byte_sel;
	} ebw_req_s;

	typedef struct packed {
		logic chip_select_five_n;
		logic rw_n;
		logic oe_n;
		logic [1:0] byte_lane_enable_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic dout_oe;
	} ebw_pins_s;

endpackage

// ### hdl/ebw_cnt.sv
// Saturating cycle counter with clear; used for wait and time-out counts.
// Assumes clear and enable are synchronous to clk.
`timescale 1ns/1ps
module ebw_cnt (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Control
	input wire logic clr,
	input wire logic inc,
	// Count
	output logic [10:0] count
);

	typedef struct packed {
		logic [10:0] cnt;
	} ebw_cnt_s;

	ebw_cnt_s st_ff;
	ebw_cnt_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (clr) begin
			nxt_st.cnt = 11'h000;
		end else if (inc && st_ff.cnt != 11'h7ff) begin
			nxt_st.cnt = st_ff.cnt + 11'h001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign count = st_ff.cnt;

endmodule

// ### testbench/ebw_mem_model.sv
// Peripheral model on chip select five: wait pulse and read data.
// Assumes pins come from ebw_cycle on the same clock.
`timescale 1ns/1ps
module ebw_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench control
	input wire logic [10:0] ack_dly,
	input wire logic ack_hold,
	input wire logic no_ack,
	// Bus side
	input wire ebw_pkg::ebw_pins_s pins,
	output logic data_ack_input_n,
	output logic [15:0] din
);
	logic [10:0] cnt_ff;
	logic sel;
	logic hit;
	logic rdy_ff;
	logic rdy;
	assign sel = !pins.chip_select_five_n;
	assign hit = sel && !no_ack && cnt_ff == ack_dly;
	// Data valid only from one clock after wait, the latest allowed
	assign rdy = sel && (rdy_ff || !data_ack_input_n);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 11'h000;
			data_ack_input_n <= 1'b1;
			rdy_ff <= 1'b0;
			din <= 16'h0000;
		end else begin
			cnt_ff <= sel ? cnt_ff + 11'h001 : 11'h000;
			// Held low in internal mode to prove it is ignored
			data_ack_input_n <= !(hit || ack_hold);
			rdy_ff <= rdy;
			// Invalid data keeps moving so no stale word looks valid
			din <= rdy ? pins.addr[15:0] ^ 16'h5a5a : ~din;
		end
	end
endmodule

// ### testbench/tb_top.sv
// Bench for ebw_cycle with a wait-driven peripheral model.
// Assumes ebw_pkg and the model are compiled first.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic wr;
		logic dma;
		logic [3:0] rsd;
		logic [3:0] sad;
		logic [3:0] wad;
		logic bec;
		logic [10:0] ad;
		logic [23:0] addr;
		logic [15:0] exp;
	} ebw_row_s;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic region_is_five = 1'b1;
	logic ce = 1'b1;
	logic req_valid = 1'b0;
	logic ack_hold = 1'b0;
	logic no_ack = 1'b0;
	logic [10:0] ack_dly = 11'h000;
	ebw_pkg::ebw_cfg_s cfg = '0;
	ebw_pkg::ebw_req_s req = '0;
	ebw_pkg::ebw_pins_s pins;
	logic req_ready, done, bus_error, ack_n, be_seen;
	logic [15:0] rdata, din, rd, d_rw;
	logic [23:0] a_cs, a_rw;
	logic [5:0] cur, prv = 6'h3f;
	int tf[6], tr[6], k[3] = '{-99, -99, -99};
	int cyc = 0, t_take, t_done, t_err, g, num_errors = 0, comparisons = 0;
	ebw_row_s r;
	ebw_row_s rows[8] = '{
		'{1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 1'b0, 11'h001, 24'h000000, 16'h5a5a},
		'{1'b0, 1'b0, 4'h3, 4'h0, 4'h0, 1'b1, 11'h005, 24'h12a5a5, 16'hffff},
		'{1'b1, 1'b0, 4'h0, 4'h0, 4'h0, 1'b0, 11'h001, 24'h00beef, 16'h1234},
		'{1'b1, 1'b0, 4'h0, 4'h2, 4'h3, 1'b0, 11'h004, 24'hfffffe, 16'hffff},
		'{1'b0, 1'b1, 4'h1, 4'h0, 4'h0, 1'b0, 11'h002, 24'hfffff0, 16'ha5aa},
		'{1'b0, 1'b1, 4'hf, 4'h0, 4'h0, 1'b0, 11'h3fb, 24'h0f0f0f, 16'h5555},
		'{1'b1, 1'b1, 4'h0, 4'h1, 4'h1, 1'b0, 11'h001, 24'h800000, 16'h0000},
		'{1'b1, 1'b1, 4'h0, 4'h0, 4'h2, 1'b0, 11'h003, 24'h7fffff, 16'h8001}};

	always #25 clk = ~clk;

	ebw_cycle i_ebw_cycle (.clk(clk), .arst_n(arst_n), .ce(ce), .cfg(cfg),
		.region_is_five(region_is_five), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .done(done), .bus_error(bus_error),
		.rdata(rdata), .data_ack_input_n(ack_n), .din(din), .pins(pins));
	ebw_mem_model i_ebw_mem_model (.clk(clk), .arst_n(arst_n),
		.ack_dly(ack_dly), .ack_hold(ack_hold), .no_ack(no_ack), .pins(pins),
		.data_ack_input_n(ack_n), .din(din));

	// Edge times of cs, oe, rw, byte lanes, data drive and wait
	always @(negedge clk) begin
		cur = {ack_n, pins.dout_oe, &pins.byte_lane_enable_n, pins.rw_n,
			pins.oe_n, pins.chip_select_five_n};
		cyc++;
		for (int i = 0; i < 6; i++) begin
			if (prv[i] && !cur[i]) tf[i] = cyc;
			if (!prv[i] && cur[i]) tr[i] = cyc;
		end
		if (!cur[3]) be_seen = 1'b1;
		if (prv[0] && !cur[0]) a_cs = pins.addr;
		if (prv[2] && !cur[2]) a_rw = pins.addr;
		if (!prv[2] && cur[2]) d_rw = pins.dout;
		if (done === 1'b1) begin
			t_done = cyc;
			rd = rdata;
		end
		if (bus_error === 1'b1) t_err = cyc;
		prv = cur;
	end

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] v);
		comparisons++;
		if (v !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask

	task automatic rng(input string n, input int lo, input int hi, input int v);
		comparisons++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, v);
		end
	endtask

	// Fixed part of a delay must not move when the field changes
	task automatic koff(input int i, input int v);
		if (k[i] == -99) k[i] = v;
		rng("delay_offset", k[i], k[i], v);
	endtask

	task automatic op(input ebw_pkg::ebw_req_s q, input ebw_pkg::ebw_cfg_s c,
		input logic [10:0] ad);
		@(posedge clk);
		cfg <= c;
		req <= q;
		ack_dly <= ad;
		req_valid <= 1'b1;
		be_seen = 1'b0;
		t_done = -1;
		t_err = -1;
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
		t_take = cyc;
		for (int i = 0; i < 1100 && t_done < 0 && t_err < 0; i++) @(negedge clk);
	endtask

	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(20000 * 50);
		num_errors++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk);
		chk("reset_pins", 24'h3e, {pins.chip_select_five_n, pins.rw_n,
			pins.oe_n, pins.byte_lane_enable_n, pins.dout_oe});
		arst_n <= 1'b1;
		foreach (rows[n]) begin
			r = rows[n];
			g = tr[0];
			op('{r.wr, r.dma, r.addr, r.exp, 2'h3},
				'{6'h3f, 1'b1, r.bec, r.rsd, r.sad, r.wad}, r.ad);
			chk("done", 1, t_done > 0);
			rng("cs_width", 3, 2000, tr[0] - tf[0]);
			if (r.dma) rng("cs_gap", 1, 99, tf[0] - g);
			if (!r.wr) begin
				chk("rd_addr", r.addr, a_cs);
				chk("rdata", r.exp, rd);
				koff(0, tf[1] - tf[0] - r.rsd);
				chk("rd_lanes", !r.bec, be_seen);
				rng("wait_oe", 2, 3, tr[1] - tf[5]);
				rng("oe_cs", 1, 1, tr[0] - tr[1]);
			end else begin
				chk("wr_addr", r.addr, a_rw);
				koff(1, tf[0] - tf[2] - r.sad);
				koff(2, tf[3] - tf[2] - r.wad);
				rng("wait_rw", 1, 2, tr[2] - tf[5]);
				rng("rw_cs", 2, 2, tr[0] - tr[2]);
				rng("wd_hold", 2, 99, tf[4] - tr[2]);
				chk("wdata", r.exp, d_rw);
			end
		end
		// Freeze only once idle, else the gap state would hold ready low
		@(posedge clk);
		ce <= 1'b0;
		op('{1'b0, 1'b0, 24'h000050, 16'h0000, 2'h3}, '{6'h3f, 1'b1, 1'b0,
			4'h0, 4'h0, 4'h0}, 11'h001);
		chk("ce_freeze", 24'h3e, {t_done > 0, pins.chip_select_five_n,
			pins.rw_n, pins.oe_n, pins.byte_lane_enable_n, pins.dout_oe});
		ce <= 1'b1;
		fork
			op('{1'b0, 1'b0, 24'h000040, 16'h0000, 2'h3}, '{6'h3f, 1'b1, 1'b0,
				4'h0, 4'h0, 4'h0}, 11'h100);
			begin
				repeat (20) @(posedge clk);
				arst_n <= 1'b0;
				repeat (2) @(posedge clk);
				chk("midrun_reset", 24'h3e, {pins.chip_select_five_n, pins.rw_n,
					pins.oe_n, pins.byte_lane_enable_n, pins.dout_oe});
				arst_n <= 1'b1;
			end
		join
		chk("midrun_flags", 24'h0, {t_done > 0, t_err > 0});
		ack_hold <= 1'b1;
		op('{1'b0, 1'b0, 24'h000010, 16'h0000, 2'h3}, '{6'h05, 1'b0, 1'b0,
			4'h0, 4'h0, 4'h0}, 11'h000);
		rng("internal_wait", 5, 99, tr[0] - tf[0]);
		ack_hold <= 1'b0;
		no_ack <= 1'b1;
		region_is_five <= 1'b0;
		op('{1'b0, 1'b0, 24'h000020, 16'h0000, 2'h3}, '{6'h05, 1'b1, 1'b0,
			4'h0, 4'h0, 4'h0}, 11'h000);
		chk("other_region", 24'h2, {t_done > 0, t_err > 0});
		region_is_five <= 1'b1;
		op('{1'b0, 1'b0, 24'h000030, 16'h0000, 2'h3}, '{6'h3f, 1'b1, 1'b0,
			4'h0, 4'h0, 4'h0}, 11'h000);
		chk("timeout_flags", 24'h1, {t_done > 0, t_err > 0});
		rng("timeout_age", 1022, 1026, t_err - t_take);
		chk("timeout_cs", 1, pins.chip_select_five_n);
		results();
	end
endmodule
